// *** common/rrcf_pkg.sv ***
// package for the four-channel receive range control and framer block
// assumes a 25 MHz system clock and deserialized 10-bit words arriving in step with it
package rrcf_pkg;

  // channel count and character width
  localparam int NUM_CH = 4;
  localparam int WORD_W = 10;

  // register byte offsets on the bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FRAMED = 8'h08;

  // per-channel control byte: field positions
  localparam int CF_ENABLE    = 0;
  localparam int CF_FRAMER_EN = 1;
  localparam int CF_PATSEL    = 2;
  localparam int CF_MODE_LO   = 3;
  localparam int CF_INSEL     = 5;
  localparam int CF_HALFREF   = 6;
  localparam int CF_UNLOCK    = 7;
  localparam int CTRL_LANE_W  = 8;

  // per-channel status byte: field positions
  localparam int SF_LINK_OK   = 0;
  localparam int SF_FORCED    = 1;
  localparam int SF_OFFSET_LO = 2;

  // values after reset
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [3:0]  OFFSET_RESET = 4'h0;

  // range monitor: interval in recovered byte clocks and allowed deviation
  localparam int RANGE_INTERVAL = 4096;
  localparam int RANGE_PPM      = 1500;
  localparam int RANGE_TOL_FULL = (RANGE_INTERVAL * RANGE_PPM) / 1000000;
  localparam int RANGE_TOL_HALF = (RANGE_INTERVAL / 2 * RANGE_PPM) / 1000000;
  localparam int RANGE_CNT_W    = 13;

  // framer timing
  localparam int MULTI_SPAN_BITS = 50;
  localparam int MULTI_MAX_GAP   = MULTI_SPAN_BITS / WORD_W - 1;
  localparam int ALT_REPEAT      = 4;
  localparam int LL_MAX_STEP     = 2;

  // transition density: longest run of characters without a transition
  localparam int IDLE_BITS  = 60;
  localparam int IDLE_WORDS = IDLE_BITS / WORD_W;

  // framer alignment mode encodings
  typedef enum logic [1:0] {
    RRCF_MODE_LOWLAT = 2'b00,
    RRCF_MODE_ALT    = 2'b01,
    RRCF_MODE_MULTI  = 2'b10,
    RRCF_MODE_RSVD   = 2'b11
  } rrcf_mode_t;

  // framing patterns, first received bit leftmost
  localparam logic [9:0] PAT_COMMA_POS = 10'h0f8;
  localparam logic [9:0] PAT_COMMA_NEG = 10'h304;
  localparam logic [9:0] PAT_COMMA_MSK = 10'h3fc;
  localparam logic [9:0] PAT_K_NEG     = 10'h0fa;
  localparam logic [9:0] PAT_K_POS     = 10'h305;
  localparam logic [9:0] PAT_FULL_MSK  = 10'h3ff;

endpackage

// *** logic/rrcf_framer.sv ***
// character framer for one receive channel
// assumes one raw 10-bit word per word_valid, first received bit in bit 9
`timescale 1ns/1ps
module rrcf_framer (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic       enable,
  input  wire logic       framer_enable,
  input  wire logic       pattern_select,
  input  wire logic [1:0] mode,
  input  wire logic       word_valid,
  input  wire logic [9:0] raw_word,
  output logic [9:0]      aligned_word,
  output logic            aligned_valid,
  output logic [3:0]      offset,
  output logic [1:0]      stretch_bits
);
  import rrcf_pkg::*;

  typedef enum logic {FR_HUNT, FR_CONFIRM} rrcf_fstate_t;

  rrcf_fstate_t fstate;
  logic [9:0]   prev_word;
  logic [19:0]  hist;
  logic [9:0]   det;
  logic         hit;
  logic [3:0]   hit_off;
  logic [3:0]   target;
  logic [3:0]   cand;
  logic [2:0]   gap;
  logic [2:0]   rep;
  logic [3:0]   step;
  rrcf_mode_t   fmode;

  assign hist  = {prev_word, raw_word};
  assign fmode = rrcf_mode_t'(mode);

  // compare every bit offset at once; X bits of the comma form are masked out
  generate
    for (genvar o = 0; o < WORD_W; o++) begin : g_off
      logic [9:0] win;
      assign win = hist[19-o -: 10];
      assign det[o] = pattern_select ?
        (win == PAT_K_NEG || win == PAT_K_POS) :
        ((win & PAT_COMMA_MSK) == PAT_COMMA_POS ||
         (win & PAT_COMMA_MSK) == PAT_COMMA_NEG);
    end
  endgenerate

  // lowest offset wins if more than one position matches
  always_comb begin
    hit     = 1'b0;
    hit_off = 4'h0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      if (det[i]) begin
        hit     = 1'b1;
        hit_off = 4'(i);
      end
    end
  end

  // low-latency moves forward at most two bits per character so the clock only stretches a little
  always_comb begin
    if (target > offset) begin
      step = (target - offset > 4'(LL_MAX_STEP)) ? 4'(LL_MAX_STEP) : target - offset;
    end else begin
      step = 4'h0;
    end
  end

  // history word and aligned output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_word     <= 10'h000;
      aligned_word  <= 10'h000;
      aligned_valid <= 1'b0;
    end else if (ce) begin
      aligned_valid <= word_valid && enable;
      if (word_valid) begin
        prev_word    <= raw_word;
        aligned_word <= hist[19-offset -: 10];
      end
    end
  end

  // boundary decision per mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fstate       <= FR_HUNT;
      offset       <= OFFSET_RESET;
      target       <= OFFSET_RESET;
      cand         <= OFFSET_RESET;
      gap          <= 3'h0;
      rep          <= 3'h0;
      stretch_bits <= 2'h0;
    end else if (ce) begin
      stretch_bits <= 2'h0;
      if (!enable || !framer_enable) begin
        fstate <= FR_HUNT;
        target <= offset;
        rep    <= 3'h0;
      end else if (word_valid) begin
        case (fmode)
          RRCF_MODE_LOWLAT: begin
            if (hit) begin
              target <= hit_off;
            end
            if (target < offset) begin
              offset <= target;           // a wrap backwards costs no stretch
            end else begin
              offset       <= offset + step;
              stretch_bits <= step[1:0];
            end
          end
          RRCF_MODE_MULTI: begin
            if (hit && fstate == FR_CONFIRM && hit_off == cand && gap <= 3'(MULTI_MAX_GAP)) begin
              offset <= cand;
              target <= cand;
              fstate <= FR_HUNT;
            end else if (hit) begin
              cand   <= hit_off;
              gap    <= 3'h1;
              fstate <= FR_CONFIRM;
            end else if (fstate == FR_CONFIRM) begin
              if (gap >= 3'(MULTI_MAX_GAP)) begin
                fstate <= FR_HUNT;
              end else begin
                gap <= gap + 3'h1;
              end
            end
          end
          RRCF_MODE_ALT: begin
            if (hit && (rep == 3'h0 || hit_off == cand)) begin
              cand <= hit_off;
              if (rep == 3'(ALT_REPEAT - 1)) begin
                offset <= hit_off;
                target <= hit_off;
                rep    <= 3'h0;
              end else begin
                rep <= rep + 3'h1;
              end
            end else if (hit) begin
              cand <= hit_off;
              rep  <= 3'h1;
            end else begin
              rep <= 3'h0;
            end
          end
          default: begin
            target <= offset;
          end
        endcase
      end
    end
  end

endmodule // rrcf_framer

// *** logic/rrcf_range.sv ***
// range monitor for one receive channel
// assumes byte_tick and ref_tick are one-cycle pulses already synchronous to hclk
`timescale 1ns/1ps
module rrcf_range (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic half_ref,
  input  wire logic byte_tick,
  input  wire logic ref_tick,
  output logic      force_ref,
  output logic      in_range
);
  import rrcf_pkg::*;

  logic [RANGE_CNT_W-1:0] byte_cnt;
  logic [RANGE_CNT_W-1:0] ref_cnt;
  logic [RANGE_CNT_W-1:0] expect_cnt;
  logic [RANGE_CNT_W-1:0] tol_cnt;
  logic [RANGE_CNT_W-1:0] diff;
  logic                   interval_end;
  logic                   deviates;

  // a half-rate reference gives half the count per interval
  assign expect_cnt   = half_ref ? RANGE_CNT_W'(RANGE_INTERVAL / 2) : RANGE_CNT_W'(RANGE_INTERVAL);
  assign tol_cnt      = half_ref ? RANGE_CNT_W'(RANGE_TOL_HALF) : RANGE_CNT_W'(RANGE_TOL_FULL);
  assign interval_end = byte_tick && (byte_cnt == RANGE_CNT_W'(RANGE_INTERVAL - 1));
  assign diff         = (ref_cnt > expect_cnt) ? ref_cnt - expect_cnt : expect_cnt - ref_cnt;
  assign deviates     = diff > tol_cnt;

  // interval counters; ref count saturates so a runaway oscillator cannot wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_cnt <= '0;
      ref_cnt  <= '0;
    end else if (ce) begin
      if (!enable || interval_end) begin
        byte_cnt <= '0;
        ref_cnt  <= '0;
      end else begin
        if (byte_tick) begin
          byte_cnt <= byte_cnt + 1'b1;
        end
        if (ref_tick && ref_cnt != '1) begin
          ref_cnt <= ref_cnt + 1'b1;
        end
      end
    end
  end

  // force for one whole interval, then release to retry lock on the data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      force_ref <= 1'b0;
      in_range  <= 1'b0;
    end else if (ce) begin
      if (!enable) begin
        force_ref <= 1'b0;
        in_range  <= 1'b0;
      end else if (interval_end) begin
        force_ref <= force_ref ? 1'b0 : deviates;
        in_range  <= !force_ref && !deviates;
      end else if (force_ref) begin
        in_range  <= 1'b0;
      end
    end
  end

endmodule // rrcf_range

// *** logic/rrcf_top.sv ***
// four-channel receive range control, link fault and framer, with an AHB-Lite register slave
// assumes the recovered byte and reference ticks and raw words are synchronous to hclk
`timescale 1ns/1ps
module rrcf_top (
  input  wire logic                                         hclk,
  input  wire logic                                         hresetn,
  input  wire logic                                         ce,
  input  wire logic                                         hsel,
  input  wire logic [31:0]                                  haddr,
  input  wire logic [1:0]                                   htrans,
  input  wire logic                                         hwrite,
  input  wire logic [2:0]                                   hsize,
  input  wire logic [31:0]                                  hwdata,
  input  wire logic                                         hready,
  output logic [31:0]                                       hrdata,
  output logic                                              hreadyout,
  output logic                                              hresp,
  input  wire logic [rrcf_pkg::NUM_CH-1:0]                  rx_byte_tick,
  input  wire logic [rrcf_pkg::NUM_CH-1:0]                  ref_tick,
  input  wire logic [rrcf_pkg::NUM_CH-1:0]                  reference_present,
  input  wire logic [rrcf_pkg::NUM_CH-1:0]                  amplitude_ok,
  input  wire logic [rrcf_pkg::NUM_CH-1:0]                  rx_word_valid,
  input  wire logic [rrcf_pkg::NUM_CH*rrcf_pkg::WORD_W-1:0] rx_raw_word,
  output logic [rrcf_pkg::NUM_CH-1:0]                       rx_channel_enable,
  output logic [rrcf_pkg::NUM_CH-1:0]                       line_input_select,
  output logic [rrcf_pkg::NUM_CH-1:0]                       receive_clock_pll_force,
  output logic [rrcf_pkg::NUM_CH-1:0]                       link_fault_n,
  output logic [rrcf_pkg::NUM_CH*rrcf_pkg::WORD_W-1:0]      rx_framed_word,
  output logic [rrcf_pkg::NUM_CH-1:0]                       rx_framed_valid,
  output logic [rrcf_pkg::NUM_CH*2-1:0]                     clock_stretch_bits
);
  import rrcf_pkg::*;

  // bus state
  logic        dphase_write;
  logic [7:0]  dphase_addr;
  logic        take;
  logic [31:0] ctrl;
  logic [31:0] status_word;
  logic [31:0] next_rdata;

  // per-channel internal state
  logic [NUM_CH-1:0]   force_ref;
  logic [NUM_CH-1:0]   in_range;
  logic [NUM_CH-1:0]   idle_fault;
  logic [NUM_CH*4-1:0] offsets;
  logic [NUM_CH*10-1:0] framed;
  logic [NUM_CH-1:0]   framed_valid;
  logic [NUM_CH*2-1:0] stretch;

  // an address phase is taken only when selected, non-idle and the bus is ready
  assign take = hsel && htrans[1] && hready;

  // address phase capture; single-cycle data phase, so the slave never stalls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_write <= 1'b0;
      dphase_addr  <= 8'h00;
    end else if (ce) begin
      dphase_write <= take && hwrite;
      dphase_addr  <= haddr[7:0];
    end
  end

  // control register: any write to offset 0 updates the whole word; hsize is not checked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
    end else if (ce) begin
      if (dphase_write && dphase_addr == ADDR_CTRL) begin
        ctrl <= hwdata;
      end
    end
  end

  // status gathers each channel's own state for software
  always_comb begin
    status_word = 32'h0000_0000;
    for (int c = 0; c < NUM_CH; c++) begin
      status_word[c*CTRL_LANE_W + SF_LINK_OK]            = link_fault_n[c];
      status_word[c*CTRL_LANE_W + SF_FORCED]             = force_ref[c];
      status_word[c*CTRL_LANE_W + SF_OFFSET_LO +: 4]     = offsets[c*4 +: 4];
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (haddr[7:0])
      ADDR_CTRL:   next_rdata = ctrl;
      ADDR_STATUS: next_rdata = status_word;
      ADDR_FRAMED: next_rdata = {28'h000_0000, rx_framed_valid};
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  // read data is registered at the address phase so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      if (take && !hwrite) begin
        hrdata <= next_rdata;
      end
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // one range monitor, framer, idle detector and fault flag per channel
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [7:0] lane;
      logic [9:0] word;
      logic [9:0] prev_word;
      logic [2:0] idle_cnt;
      logic       flat;

      assign lane = ctrl[c*CTRL_LANE_W +: CTRL_LANE_W];
      assign word = rx_raw_word[c*WORD_W +: WORD_W];
      // a word with no edge inside it and none against the previous word's last bit
      assign flat = (word == 10'h000 || word == 10'h3ff) && (word[9] == prev_word[0]);

      // the half-rate reference choice sets the expected count per interval
      rrcf_range u_range (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .enable    (lane[CF_ENABLE]),
        .half_ref  (lane[CF_HALFREF]),
        .byte_tick (rx_byte_tick[c]),
        .ref_tick  (ref_tick[c]),
        .force_ref (force_ref[c]),
        .in_range  (in_range[c])
      );

      rrcf_framer u_framer (
        .hclk           (hclk),
        .hresetn        (hresetn),
        .ce             (ce),
        .enable         (lane[CF_ENABLE]),
        .framer_enable  (lane[CF_FRAMER_EN]),
        .pattern_select (lane[CF_PATSEL]),
        .mode           (lane[CF_MODE_LO +: 2]),
        .word_valid     (rx_word_valid[c]),
        .raw_word       (word),
        .aligned_word   (framed[c*10 +: 10]),
        .aligned_valid  (framed_valid[c]),
        .offset         (offsets[c*4 +: 4]),
        .stretch_bits   (stretch[c*2 +: 2])
      );

      // run of flat characters; more than six of them means a dead line
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          prev_word     <= 10'h000;
          idle_cnt      <= 3'h0;
          idle_fault[c] <= 1'b1;
        end else if (ce) begin
          if (!lane[CF_ENABLE]) begin
            idle_cnt      <= 3'h0;
            idle_fault[c] <= 1'b1;
          end else if (rx_word_valid[c]) begin
            prev_word <= word;
            if (!flat) begin
              idle_cnt      <= 3'h0;
              idle_fault[c] <= 1'b0;
            end else if (idle_cnt == 3'(IDLE_WORDS)) begin
              idle_fault[c] <= 1'b1;
            end else begin
              idle_cnt <= idle_cnt + 3'h1;
            end
          end
        end
      end

      // the fault flag follows all conditions at once, in step with the clock
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          link_fault_n[c] <= 1'b0;
        end else if (ce) begin
          link_fault_n[c] <= lane[CF_ENABLE] && amplitude_ok[c] && !idle_fault[c]
                             && in_range[c] && !force_ref[c] && reference_present[c]
                             && !lane[CF_UNLOCK];
        end
      end
    end
  endgenerate

  // pin outputs registered from control and channel state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_channel_enable       <= '0;
      line_input_select       <= '0;
      receive_clock_pll_force <= '0;
      rx_framed_word          <= '0;
      rx_framed_valid         <= '0;
      clock_stretch_bits      <= '0;
    end else if (ce) begin
      for (int c = 0; c < NUM_CH; c++) begin
        rx_channel_enable[c] <= ctrl[c*CTRL_LANE_W + CF_ENABLE];
        line_input_select[c] <= ctrl[c*CTRL_LANE_W + CF_INSEL];
      end
      receive_clock_pll_force <= force_ref;
      rx_framed_word          <= framed;
      rx_framed_valid         <= framed_valid;
      clock_stretch_bits      <= stretch;
    end
  end

endmodule // rrcf_top

// *** sim/rrcf_remote_tx.sv ***
// remote transmitter model: alternating full framing characters at a bit shift
// assumes one word and one byte tick per hclk, bit 9 of a word sent first
`timescale 1ns/1ps
module rrcf_remote_tx (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       flat,
  input  wire logic       slow_ref,
  input  wire logic [3:0] shift,
  output logic            byte_tick,
  output logic            ref_tick,
  output logic            word_valid,
  output logic [9:0]      raw_word
);
  import rrcf_pkg::*;
  logic [9:0] cur;
  logic [2:0] n;
  // both disparities are bit inverses, so toggling gives a legal stream
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= PAT_K_NEG;
      n   <= 3'h0;
    end else begin
      cur <= ~cur;
      n   <= n + 3'h1;
    end
  end
  // dropping one reference tick in eight puts the rate far outside the limit
  assign ref_tick   = hresetn && !(slow_ref && n == 3'h0);
  assign byte_tick  = hresetn;
  assign word_valid = hresetn;
  assign raw_word   = flat ? 10'h000 : 10'({~cur, cur} >> shift);
endmodule // rrcf_remote_tx

// *** sim/rrcf_top_bench.sv ***
// self-checking bench for rrcf_top, all channels fed by one remote model
// assumes zero-wait bus and channel 0 control in byte 0 of the control word
`timescale 1ns/1ps
module rrcf_top_bench;
  import rrcf_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, flat, slow_ref;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [3:0]  shift, amp_ok, ref_ok;
  wire  [31:0] hrdata;
  wire         hreadyout, bt, rt, wv;
  wire  [9:0]  rw;
  wire  [3:0]  rx_en, insel, force_ref, link_fault_n;
  wire  [39:0] framed;
  int          mismatches, cmp_count;

  rrcf_remote_tx far (.hclk, .hresetn, .flat, .slow_ref, .shift, .byte_tick(bt), .ref_tick(rt),
    .word_valid(wv), .raw_word(rw));
  rrcf_top dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .rx_byte_tick({4{bt}}), .ref_tick({4{rt}}),
    .reference_present(ref_ok), .amplitude_ok(amp_ok), .rx_word_valid({4{wv}}), .rx_raw_word({4{rw}}),
    .rx_channel_enable(rx_en), .line_input_select(insel), .receive_clock_pll_force(force_ref),
    .link_fault_n, .rx_framed_word(framed), .rx_framed_valid(), .clock_stretch_bits());

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  // one single word transfer; holds each phase until hready is seen high
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // sel 0 polls channel 0 link, sel 1 its forced flag
  task automatic wait_for(input int sel, input logic v, input int lim);
    int i;
    i = 0;
    while ((sel == 0 ? link_fault_n[0] : force_ref[0]) !== v && i < lim) begin
      @(posedge hclk);
      i++;
    end
    chk({31'h0, i < lim}, 32'h1, "wait ran out");
  endtask

  task automatic t_regs;
    chk({28'h0, link_fault_n}, 32'h0, "fault after reset");
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, CTRL_RESET, "control reset value");
    ahb(1'b1, 32'h0, 32'h0000_0021);
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd, 32'h0000_0021, "control readback");
    chk({28'h0, insel}, 32'h1, "input select");
    ahb(1'b1, 32'h4, 32'hffff_ffff);
    ahb(1'b0, 32'h4, 32'h0);
    chk({8'h0, rd[31:8]}, 32'h0, "status of idle channels");
    ahb(1'b0, 32'h0c, 32'h0);
    chk(rd, 32'h0, "unmapped read");
  endtask

  task automatic t_link;
    ahb(1'b1, 32'h0, 32'h0000_0003);
    wait_for(0, 1'b1, 8300);
    chk({28'h0, link_fault_n}, 32'h1, "disabled channels fault");
    flat <= 1'b1;
    repeat (12) @(posedge hclk);
    chk({31'h0, link_fault_n[0]}, 32'h0, "flat line");
    flat <= 1'b0;
    wait_for(0, 1'b1, 8300);
    ahb(1'b1, 32'h0, 32'h0000_0083);
    repeat (3) @(posedge hclk);
    chk({31'h0, link_fault_n[0]}, 32'h0, "unlock forces fault");
    ahb(1'b1, 32'h0, 32'h0000_0003);
    wait_for(0, 1'b1, 8);
    amp_ok <= 4'he;
    repeat (3) @(posedge hclk);
    chk({31'h0, link_fault_n[0]}, 32'h0, "low amplitude forces fault");
    amp_ok <= 4'hf;
    wait_for(0, 1'b1, 8);
    ref_ok <= 4'he;
    repeat (3) @(posedge hclk);
    chk({31'h0, link_fault_n[0]}, 32'h0, "missing reference forces fault");
    ref_ok <= 4'hf;
    slow_ref <= 1'b1;
    wait_for(1, 1'b1, 8300);
    @(posedge hclk);
    chk({31'h0, link_fault_n[0]}, 32'h0, "fault while forced");
    wait_for(1, 1'b0, 4200);
    slow_ref <= 1'b0;
    // half-rate choice against a full-rate reference must read as out of range
    ahb(1'b1, 32'h0, 32'h0000_0043);
    wait_for(1, 1'b1, 8300);
  endtask

  // al: framed words should be whole framing characters after the wait
  task automatic t_frame(input logic [7:0] c, input logic [3:0] s, input logic al);
    ahb(1'b1, 32'h0, {24'h0, c});
    shift <= s;
    repeat (11) @(posedge hclk);
    chk({31'h0, framed[9:0] === PAT_K_NEG || framed[9:0] === PAT_K_POS}, {31'h0, al}, "framed word");
  endtask

  task automatic test_done;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    flat = 1'b0;
    slow_ref = 1'b0;
    shift = 4'h0;
    amp_ok = 4'hf;
    ref_ok = 4'hf;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_link();
    t_frame(8'h1b, 4'h3, 1'b0);
    t_frame(8'h01, 4'h3, 1'b0);
    t_frame(8'h03, 4'h3, 1'b1);
    ahb(1'b0, 32'h4, 32'h0);
    chk({28'h0, rd[5:2]}, 32'h3, "bit offset");
    t_frame(8'h0f, 4'h6, 1'b1);
    t_frame(8'h13, 4'h1, 1'b1);
    t_frame(8'h01, 4'h4, 1'b0);
    test_done();
  end

  // about 16.5k cycles expected; over three times that means a hang
  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    test_done();
  end
endmodule // rrcf_top_bench

// *** sim/rrcf_top_chk_sva.sv ***
// port checker for rrcf_top: link fault, framer and control relations
// assumes one hclk domain and zero-wait bus writes to the control word
`timescale 1ns/1ps
module rrcf_top_chk (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [3:0]  amplitude_ok,
  input wire logic [3:0]  reference_present,
  input wire logic [3:0]  rx_word_valid,
  input wire logic [39:0] rx_raw_word,
  input wire logic [3:0]  rx_channel_enable,
  input wire logic [3:0]  line_input_select,
  input wire logic [3:0]  receive_clock_pll_force,
  input wire logic [3:0]  link_fault_n,
  input wire logic [3:0]  rx_framed_valid,
  input wire logic [7:0]  clock_stretch_bits
);
  wire [3:0] wd_en = {hwdata[24], hwdata[16], hwdata[8], hwdata[0]};
  wire [3:0] wd_sel = {hwdata[29], hwdata[21], hwdata[13], hwdata[5]};
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // control write: address phase, then the data phase cycle
  sequence ctrl_wr;
    hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00 ##1 1'b1;
  endsequence
  // eight flat words on channel 0 exceed sixty bits without a transition
  sequence flat8;
    (rx_word_valid[0] && rx_raw_word[9:0] == 10'h000) [*8];
  endsequence
  fault_forced_a: assert property (
    (receive_clock_pll_force & $past(receive_clock_pll_force) & link_fault_n) == 4'h0)
    else $error("link good while forced");
  fault_disabled_a: assert property (
    (~rx_channel_enable & ~$past(rx_channel_enable) & link_fault_n) == 4'h0)
    else $error("link good while disabled");
  link_cond_a: assert property (
    (link_fault_n & ~$past(amplitude_ok & reference_present & rx_channel_enable)) == 4'h0)
    else $error("link good without all conditions");
  stretch_max_a: assert property (
    (clock_stretch_bits & (clock_stretch_bits >> 1) & 8'h55) == 8'h00)
    else $error("stretch above two bits");
  // framer output flop plus pin flop: two cycles after the raw word, gated by the enable latch
  framed_cause_a: assert property (
    rx_framed_valid == ($past(rx_word_valid, 2) & $past(rx_channel_enable)))
    else $error("framed valid not following raw word");
  // control word lands after the data phase, the pin one cycle later
  enable_apply_a: assert property (ctrl_wr |=> ##1 rx_channel_enable == $past(wd_en, 2))
    else $error("enable not taken from write");
  insel_apply_a: assert property (ctrl_wr |=> ##1 line_input_select == $past(wd_sel, 2))
    else $error("input select not taken from write");
  idle_fault_a: assert property (flat8 |-> ##[1:2] !link_fault_n[0])
    else $error("no fault on flat line");
endmodule // rrcf_top_chk

bind rrcf_top rrcf_top_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .amplitude_ok, .reference_present, .rx_word_valid, .rx_raw_word, .rx_channel_enable, .line_input_select,
  .receive_clock_pll_force, .link_fault_n, .rx_framed_valid, .clock_stretch_bits);
